// ===== scp_defines.svh
// Register map, field positions and timing counts of the SDRAM command block
`ifndef SCP_DEFINES_SVH
`define SCP_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SCP_REG_CTRL 8'h00
`define SCP_REG_CMD 8'h04
`define SCP_REG_STAT 8'h08

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define SCP_CTRL_RDL_LSB 0
`define SCP_CTRL_WRL_LSB 2
`define SCP_CTRL_CKE_BIT 4
`define SCP_CTRL_RESET 5'h00

// ----------------------------------------------------------------
// Command word fields
// ----------------------------------------------------------------
`define SCP_CMD_OP_LSB 0
`define SCP_CMD_INST_BIT 3
`define SCP_CMD_SRC_BIT 4
`define SCP_CMD_DST_BIT 5
`define SCP_CMD_ROW_LSB 6
`define SCP_CMD_BANK_LSB 17

// ----------------------------------------------------------------
// Timing and sizes
// ----------------------------------------------------------------
`define SCP_CAS_LAT 3
`define SCP_PEND_W 7
`define SCP_FIFO_W 32
`define SCP_FIFO_D 2
`define SCP_RESP_OKAY 2'b00
`define SCP_RESP_SLVERR 2'b10

`endif

// ===== scp_pkg.sv
// Types shared by the SDRAM command block
`default_nettype none
package scp_pkg;
    // Command codes as written into the command word
    typedef enum logic [2:0] {
        SCP_OP_ROW_ACTIVATE_CMD,
        SCP_OP_PRECHARGE_ALL_CMD,
        SCP_OP_PRECHARGE_BANK_CMD,
        SCP_OP_READ,
        SCP_OP_WRITE
    } scp_op_t;
endpackage
`default_nettype wire

// ===== scp_cmd_fifo.sv
// Two-entry command buffer between the register bus and the pin engine
`timescale 1ns/1ps
`default_nettype none
`include "scp_defines.svh"
module scp_cmd_fifo #(
    parameter int W = `SCP_FIFO_W,
    parameter int D = `SCP_FIFO_D
) (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    import scp_pkg::*;
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam logic [AW:0] FULL = (AW+1)'(D);
    localparam logic [AW-1:0] LAST = AW'(D - 1);

    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    // Honest flags straight from the occupancy count
    assign in_ready = (cnt_q != FULL);
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rp_q];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Storage words need no reset, only the pointers and the count do
    always_ff @(posedge aclk)
    begin
        if (ce && push)
            mem_q[wp_q] <= in_data;
    end

    // Pointers and count
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end
        else if (ce)
        begin
            if (push)
                wp_q <= (wp_q == LAST) ? '0 : wp_q + 1'b1;
            if (pop)
                rp_q <= (rp_q == LAST) ? '0 : rp_q + 1'b1;
            if (push && !pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop && !push)
                cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== scp_sdram_cmd.sv
// SDRAM command pins and direct-transfer strobe for a wide and a narrow interface
`timescale 1ns/1ps
`default_nettype none
`include "scp_defines.svh"
module scp_sdram_cmd (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite write
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Interface output clock
    input wire logic if_out_clock,
    // Wide interface pins
    output logic wide_chip_select_n,
    output logic wide_row_strobe_n,
    output logic wide_col_strobe_n,
    output logic wide_write_strobe_n,
    output logic [22:3] wide_ext_addr_bus,
    output logic wide_data_oe,
    output logic wide_rd_capture,
    output logic wide_direct_xfer_strobe,
    output logic wide_sdram_clk_en,
    // Narrow interface pins
    output logic narrow_chip_select_n,
    output logic narrow_row_strobe_n,
    output logic narrow_col_strobe_n,
    output logic narrow_write_strobe_n,
    output logic [20:1] narrow_ext_addr_bus,
    output logic narrow_data_oe,
    output logic narrow_rd_capture,
    output logic narrow_direct_xfer_strobe
);
    import scp_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    localparam int PW = `SCP_PEND_W;
    logic [2:0] lk_q;
    logic tick;
    logic aw_hold_q;
    logic w_hold_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_go;
    logic is_cmd;
    logic [4:0] ctrl_q;
    logic [7:0] issued_q;
    logic f_in_valid;
    logic f_in_ready;
    logic f_valid;
    logic [31:0] f_data;
    logic issue;
    scp_op_t op;
    logic inst;
    logic src;
    logic dst;
    logic [10:0] row;
    logic [8:0] bank;
    logic [2:0] rcw;
    logic pre;
    logic [1:0] rdl;
    logic [1:0] wrl;
    logic [PW-1:0] spend_q [2];
    logic [PW-1:0] cpend_q [2];
    logic [PW-1:0] smask [2];
    logic [PW-1:0] cmask [2];
    logic [1:0] cs_n_q;
    logic [1:0] ras_n_q;
    logic [1:0] cas_n_q;
    logic [1:0] we_n_q;
    logic [1:0] oe_q;
    logic [1:0] cap_q;
    logic [1:0] strobe_q;
    logic [19:0] wa_q;
    logic [19:0] na_q;
    logic cke_q;

    // Word-aligned register address
    function automatic logic [7:0] scp_word(input logic [7:0] a);
        scp_word = {a[7:2], 2'b00};
    endfunction

    // One-hot delay mark, bit 0 meaning the current interface cycle
    function automatic logic [PW-1:0] scp_mark(input logic [2:0] d);
        scp_mark = PW'(1) << d;
    endfunction

    // ----------------------------------------------------------------
    // Interface clock sampling
    // ----------------------------------------------------------------
    // Two flops resynchronise the pin; the edge is found past them
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            lk_q <= 3'h0;
        else if (ce)
            lk_q <= {lk_q[1:0], if_out_clock};
    end
    assign tick = lk_q[1] & ~lk_q[2];

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    assign is_cmd = (scp_word(awaddr_q) == `SCP_REG_CMD);
    // A full buffer stalls the write response, so no command is lost
    assign wr_go = aw_hold_q & w_hold_q & ~bvalid & (~is_cmd | f_in_ready);
    assign f_in_valid = wr_go & is_cmd;

    // Address and data are taken in either order, then answered once
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `SCP_RESP_OKAY;
        end
        else if (ce)
        begin
            if (awvalid && awready)
            begin
                awready <= 1'b0;
                aw_hold_q <= 1'b1;
                awaddr_q <= awaddr;
            end
            if (wvalid && wready)
            begin
                wready <= 1'b0;
                w_hold_q <= 1'b1;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            if (wr_go)
            begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                bvalid <= 1'b1;
                bresp <= (scp_word(awaddr_q) == `SCP_REG_CTRL || is_cmd)
                    ? `SCP_RESP_OKAY : `SCP_RESP_SLVERR;
            end
            if (bvalid && bready)
            begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // Latency and clock-enable control, low byte lane only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ctrl_q <= `SCP_CTRL_RESET;
        else if (ce && wr_go && wstrb_q[0] && scp_word(awaddr_q) == `SCP_REG_CTRL)
            ctrl_q <= wdata_q[4:0];
    end
    assign rdl = ctrl_q[`SCP_CTRL_RDL_LSB +: 2];
    assign wrl = ctrl_q[`SCP_CTRL_WRL_LSB +: 2];

    // Reads: one answer per request, unmapped words read zero with an error
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `SCP_RESP_OKAY;
        end
        else if (ce)
        begin
            if (arvalid && arready)
            begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rresp <= `SCP_RESP_OKAY;
                unique case (scp_word(araddr))
                    `SCP_REG_CTRL: rdata <= {27'h0, ctrl_q};
                    `SCP_REG_STAT: rdata <= {16'h0, issued_q, 5'h0, cke_q, ~f_in_ready, f_valid};
                    default:
                    begin
                        rdata <= 32'h0000_0000;
                        rresp <= (scp_word(araddr) == `SCP_REG_CMD)
                            ? `SCP_RESP_OKAY : `SCP_RESP_SLVERR;
                    end
                endcase
            end
            if (rvalid && rready)
            begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Command buffer
    // ----------------------------------------------------------------
    scp_cmd_fifo #(.W(`SCP_FIFO_W), .D(`SCP_FIFO_D)) u_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data(wdata_q),
        .out_valid(f_valid),
        .out_ready(tick),
        .out_data(f_data)
    );

    // ----------------------------------------------------------------
    // Command decode and strobe scheduling
    // ----------------------------------------------------------------
    assign issue = tick & f_valid;
    assign op = scp_op_t'(f_data[`SCP_CMD_OP_LSB +: 3]);
    assign inst = f_data[`SCP_CMD_INST_BIT];
    assign src = f_data[`SCP_CMD_SRC_BIT];
    assign dst = f_data[`SCP_CMD_DST_BIT];
    assign row = f_data[`SCP_CMD_ROW_LSB +: 11];
    assign bank = f_data[`SCP_CMD_BANK_LSB +: 9];

    // Row, column and write strobes, active low
    always_comb
    begin
        rcw = 3'b111;
        pre = row[10];
        unique case (op)
            SCP_OP_ROW_ACTIVATE_CMD: rcw = 3'b011;
            SCP_OP_PRECHARGE_ALL_CMD:
            begin
                rcw = 3'b010;
                pre = 1'b1;
            end
            SCP_OP_PRECHARGE_BANK_CMD:
            begin
                rcw = 3'b010;
                pre = 1'b0;
            end
            SCP_OP_READ:
            begin
                rcw = 3'b101;
                pre = 1'b0;
            end
            SCP_OP_WRITE:
            begin
                rcw = 3'b100;
                pre = 1'b0;
            end
            default: rcw = 3'b111;
        endcase
    end

    // New marks for strobe and capture, per interface
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            smask[i] = spend_q[i];
            cmask[i] = cpend_q[i];
            if (issue && inst == i[0])
            begin
                if (op == SCP_OP_READ && src)
                    smask[i] = smask[i] | scp_mark(3'(`SCP_CAS_LAT) + {1'b0, rdl});
                if (op == SCP_OP_READ && !src)
                    cmask[i] = cmask[i] | scp_mark(3'(`SCP_CAS_LAT));
                if (op == SCP_OP_WRITE && dst)
                    smask[i] = smask[i] | scp_mark({1'b0, wrl});
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin registers, updated only on interface clock rising edges
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cs_n_q <= 2'b11;
            ras_n_q <= 2'b11;
            cas_n_q <= 2'b11;
            we_n_q <= 2'b11;
            oe_q <= 2'b00;
            cap_q <= 2'b00;
            strobe_q <= 2'b00;
            wa_q <= 20'h0_0000;
            na_q <= 20'h0_0000;
            cke_q <= 1'b0;
            issued_q <= 8'h00;
            for (int i = 0; i < 2; i++)
            begin
                spend_q[i] <= '0;
                cpend_q[i] <= '0;
            end
        end
        else if (ce && tick)
        begin
            cke_q <= ctrl_q[`SCP_CTRL_CKE_BIT];
            for (int i = 0; i < 2; i++)
            begin
                // Strobe and capture fire from mark 0, the rest move down
                strobe_q[i] <= smask[i][0];
                cap_q[i] <= cmask[i][0];
                spend_q[i] <= smask[i] >> 1;
                cpend_q[i] <= cmask[i] >> 1;
                cs_n_q[i] <= 1'b1;
                ras_n_q[i] <= 1'b1;
                cas_n_q[i] <= 1'b1;
                we_n_q[i] <= 1'b1;
                oe_q[i] <= 1'b0;
                if (issue && inst == i[0] && rcw != 3'b111)
                begin
                    cs_n_q[i] <= 1'b0;
                    {ras_n_q[i], cas_n_q[i], we_n_q[i]} <= rcw;
                    oe_q[i] <= (op == SCP_OP_WRITE) && !dst;
                end
            end
            if (issue && rcw != 3'b111)
            begin
                issued_q <= issued_q + 8'h01;
                if (inst)
                    na_q <= {bank, pre, row[9:0]};
                else
                    wa_q <= {bank, pre, row[9:0]};
            end
        end
    end

    // Pins come straight from the registers above
    assign {narrow_chip_select_n, wide_chip_select_n} = cs_n_q;
    assign {narrow_row_strobe_n, wide_row_strobe_n} = ras_n_q;
    assign {narrow_col_strobe_n, wide_col_strobe_n} = cas_n_q;
    assign {narrow_write_strobe_n, wide_write_strobe_n} = we_n_q;
    assign {narrow_data_oe, wide_data_oe} = oe_q;
    assign {narrow_rd_capture, wide_rd_capture} = cap_q;
    assign {narrow_direct_xfer_strobe, wide_direct_xfer_strobe} = strobe_q;
    assign wide_ext_addr_bus = wa_q;
    assign narrow_ext_addr_bus = na_q;
    assign wide_sdram_clk_en = cke_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_CS_WITH_STROBE: assert property (
        (!wide_row_strobe_n || !wide_col_strobe_n || !wide_write_strobe_n) |-> !wide_chip_select_n)
        else $error("strobe low without chip select");
    AST_PINS_ON_EDGE: assert property (
        $changed(cs_n_q) |-> $past(tick))
        else $error("chip select moved off a clock edge");
    AST_ROW_ACTIVATE_CMD_WIDE: assert property (
        issue && ce && op == SCP_OP_ROW_ACTIVATE_CMD && !inst |=> wa_q == $past({bank, row})
        && !wide_row_strobe_n && wide_col_strobe_n && wide_write_strobe_n)
        else $error("wide activate pins wrong");
    AST_ROW_ACTIVATE_CMD_NARROW: assert property (
        issue && ce && op == SCP_OP_ROW_ACTIVATE_CMD && inst |=> na_q[10] == $past(row[10])
        && na_q[9:0] == $past(row[9:0]) && na_q[19:11] == $past(bank))
        else $error("narrow activate address wrong");
    AST_PRECHARGE: assert property (
        issue && ce && !inst && (op == SCP_OP_PRECHARGE_ALL_CMD || op == SCP_OP_PRECHARGE_BANK_CMD) |=>
        !wide_row_strobe_n && !wide_write_strobe_n && wide_col_strobe_n
        && wide_ext_addr_bus[13] == $past(op == SCP_OP_PRECHARGE_ALL_CMD))
        else $error("precharge encoding wrong");
    AST_RD_LATENCY: assert property (
        issue && ce && op == SCP_OP_READ && src && !inst |=> spend_q[0][$past(rdl) + 2])
        else $error("read strobe not scheduled at latency");
    AST_WR_ZERO_LAT: assert property (
        issue && ce && op == SCP_OP_WRITE && dst && !inst && wrl == 2'b00 |=> wide_direct_xfer_strobe)
        else $error("zero latency write strobe missing");
    AST_NO_MODE_NO_STROBE: assert property (
        issue && ce && !inst && !(op == SCP_OP_READ && src) && !(op == SCP_OP_WRITE && dst)
        |=> spend_q[0] == ($past(spend_q[0]) >> 1))
        else $error("strobe scheduled without mode bit");
    AST_XFER_WRITE_HIZ: assert property (
        issue && ce && op == SCP_OP_WRITE && dst |=> oe_q == 2'b00)
        else $error("data driven during direct-transfer write");
    AST_XFER_READ_NOCAP: assert property (
        issue && ce && op == SCP_OP_READ && src && !inst |=> cpend_q[0] == ($past(cpend_q[0]) >> 1))
        else $error("direct-transfer read captured");
    AST_CKE_FOLLOWS: assert property (
        tick && ce |=> wide_sdram_clk_en == $past(ctrl_q[`SCP_CTRL_CKE_BIT]))
        else $error("clock enable not updated");

    COV_ROW_ACTIVATE_CMD: cover property (issue && op == SCP_OP_ROW_ACTIVATE_CMD);
    COV_RD_STROBE: cover property ((wide_direct_xfer_strobe || narrow_direct_xfer_strobe) && rdl == 2'b11);
    COV_FULL_STALL: cover property (aw_hold_q && w_hold_q && is_cmd && !f_in_ready);
endmodule
`default_nettype wire

// ===== scp_far_model.sv
// Far-side model: free-running interface clock and SDRAM command capture
`timescale 1ns/1ps
`default_nettype none
module scp_far_model (
    // Link clock and sampling clock
    output logic if_out_clock,
    input wire logic aclk,
    // Observed command pins
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    // Last command seen, as row, column and write strobe levels
    output logic [2:0] last_cmd
);
    // Runs free, off phase from aclk, so no edge ever coincides with a rising aclk edge
    initial
    begin
        if_out_clock = 1'b0;
        #7;
        forever #24 if_out_clock = ~if_out_clock;
    end
    // Memory takes a command only while selected
    always @(posedge aclk)
    begin
        if (cs_n === 1'b0) last_cmd <= {ras_n, cas_n, we_n};
    end
endmodule
`default_nettype wire

// ===== tb_top.sv
// Testbench for the SDRAM command block
`timescale 1ns/1ps
`default_nettype none
`include "scp_defines.svh"
module tb_top;
    import scp_pkg::*;
    logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready, nar, lkp;
    logic awready, wready, bvalid, arready, rvalid, if_out_clock;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] bresp, rresp, rs;
    logic w_cs, w_ras, w_cas, w_we, w_oe, w_cap, w_st, w_cke;
    logic n_cs, n_ras, n_cas, n_we, n_oe, n_cap, n_st, cs, st, cap, oe;
    logic [19:0] w_ab, n_ab, ab, ca;
    logic [2:0] w_lc, n_lc, lc;
    int fails, cmp_count, ncmd, sd, cd, od;

    // 200 MHz system clock
    always #2.5 aclk = ~aclk;
    // Watch whichever interface the current command went to
    assign cs = nar ? n_cs : w_cs;
    assign st = nar ? n_st : w_st;
    assign cap = nar ? n_cap : w_cap;
    assign oe = nar ? n_oe : w_oe;
    assign ab = nar ? n_ab : w_ab;
    assign lc = nar ? n_lc : w_lc;

    scp_sdram_cmd dut_u (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .if_out_clock(if_out_clock), .wide_chip_select_n(w_cs), .wide_row_strobe_n(w_ras),
        .wide_col_strobe_n(w_cas), .wide_write_strobe_n(w_we), .wide_ext_addr_bus(w_ab),
        .wide_data_oe(w_oe), .wide_rd_capture(w_cap), .wide_direct_xfer_strobe(w_st),
        .wide_sdram_clk_en(w_cke), .narrow_chip_select_n(n_cs), .narrow_row_strobe_n(n_ras),
        .narrow_col_strobe_n(n_cas), .narrow_write_strobe_n(n_we),
        .narrow_ext_addr_bus(n_ab), .narrow_data_oe(n_oe), .narrow_rd_capture(n_cap),
        .narrow_direct_xfer_strobe(n_st)
    );
    scp_far_model wide_mem_u (.if_out_clock(if_out_clock), .aclk(aclk), .cs_n(w_cs),
        .ras_n(w_ras), .cas_n(w_cas), .we_n(w_we), .last_cmd(w_lc));
    scp_far_model narrow_mem_u (.if_out_clock(), .aclk(aclk), .cs_n(n_cs),
        .ras_n(n_ras), .cas_n(n_cas), .we_n(n_we), .last_cmd(n_lc));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task stop_test;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task tmo(input int i);
        if (i >= 300)
        begin
            fails++;
            stop_test;
        end
    endtask
    // Address and data offered together, each dropped once taken
    task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int i;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        i = 0;
        do
        begin
            @(posedge aclk);
            i++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && i < 300);
        tmo(i);
        r = bresp;
        bready <= 1'b0;
    endtask
    task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int i;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        i = 0;
        do
        begin
            @(posedge aclk);
            i++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && i < 300);
        tmo(i);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // Issue one command, then count link edges from its select to each pin event
    task run(input logic [2:0] op, input logic n, s, dm, input logic [19:0] ba);
        int i, k;
        sd = -1;
        cd = -1;
        od = -1;
        k = 0;
        nar = n;
        axw(`SCP_REG_CMD, {6'h00, ba, dm, s, n, op}, rs);
        ncmd++;
        i = 0;
        while (cs !== 1'b0 && i < 300)
        begin
            @(posedge aclk);
            i++;
        end
        tmo(i);
        ca = ab;
        lkp = if_out_clock;
        for (i = 0; i < 70; i++)
        begin
            if (st === 1'b1 && sd < 0) sd = k;
            if (cap === 1'b1 && cd < 0) cd = k;
            if (oe === 1'b1 && od < 0) od = k;
            @(posedge aclk);
            if (if_out_clock && !lkp) k++;
            lkp = if_out_clock;
        end
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial
    begin
        aclk = 0;
        aresetn = 0;
        ce = 1;
        awvalid = 0;
        wvalid = 0;
        bready = 0;
        arvalid = 0;
        rready = 0;
        nar = 0;
        awaddr = 0;
        araddr = 0;
        wdata = 0;
        fails = 0;
        cmp_count = 0;
        ncmd = 0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check({w_cs, w_ras, w_cas, w_we, n_cs, n_ras, n_cas, n_we}, 8'hff);
        check({w_st, n_st, w_oe, n_oe, w_cke}, 5'h00);
        axr(`SCP_REG_CTRL, rd, rs);
        check(rd, 32'h0);
        axw(8'h0c, 32'h1, rs);
        check(rs, 2'b10);
        axr(8'h0c, rd, rs);
        check({rs, rd[29:0]}, 32'h80000000);
        axw(`SCP_REG_CTRL, 32'h10, rs);
        for (int i = 0; i < 100 && w_cke !== 1'b1; i++) @(posedge aclk);
        check(w_cke, 1'b1);
        axr(`SCP_REG_STAT, rd, rs);
        check(rd[2], 1'b1);
        // Activate on each interface, row bit set to reach the precharge pin
        for (int n = 0; n < 2; n++)
        begin
            run(SCP_OP_ROW_ACTIVATE_CMD, n[0], 1'b0, 1'b0, n ? 20'h54f3a : 20'hab6c5);
            check(lc, 3'b011);
            check(ca, n ? 20'h54f3a : 20'hab6c5);
        end
        run(SCP_OP_PRECHARGE_ALL_CMD, 1'b0, 1'b0, 1'b0, 20'h00000);
        check({lc, ca[10]}, 4'b0101);
        run(SCP_OP_PRECHARGE_BANK_CMD, 1'b1, 1'b0, 1'b0, 20'hfffff);
        check({lc, ca[10]}, 4'b0100);
        // Every read and write latency code, alternating interfaces
        for (int l = 0; l < 4; l++)
        begin
            axw(`SCP_REG_CTRL, 32'h10 | l | (l << 2), rs);
            run(SCP_OP_READ, l[0], 1'b1, 1'b0, 20'h00000);
            check(sd, 3 + l);
            check(cd, -1);
            check(lc, 3'b101);
            run(SCP_OP_WRITE, l[0], 1'b0, 1'b1, 20'h00000);
            check(sd, l);
            check(od, -1);
            check(lc, 3'b100);
        end
        // Other direction's mode bit must not raise the strobe
        run(SCP_OP_READ, 1'b0, 1'b0, 1'b1, 20'h00000);
        check(sd, -1);
        check(cd, 3);
        run(SCP_OP_WRITE, 1'b1, 1'b1, 1'b0, 20'h00000);
        check(sd, -1);
        check(od, 0);
        // Enable low freezes the pins; a queued command must wait, not vanish
        axw(`SCP_REG_CMD, 32'h0, rs);
        ncmd++;
        ce <= 1'b0;
        @(posedge aclk);
        lkp = w_cs;
        sd = 0;
        for (int i = 0; i < 40; i++)
        begin
            @(posedge aclk);
            if (w_cs !== lkp) sd++;
        end
        ce <= 1'b1;
        check(sd, 0);
        // Illegal code is dropped; a burst fills the buffer but loses nothing
        axw(`SCP_REG_CMD, 32'h5, rs);
        for (int b = 0; b < 4; b++) axw(`SCP_REG_CMD, 32'h0, rs);
        ncmd += 4;
        rd = 32'h1;
        for (int i = 0; i < 100 && rd[0] !== 1'b0; i++) axr(`SCP_REG_STAT, rd, rs);
        check(rd[15:8], ncmd[7:0]);
        stop_test;
    end
endmodule
`default_nettype wire
